//--- src/gat_alarm.sv
// Purpose: Two-level gas alarm evaluation, keypad settings menu, relay drive
// Assumes: Concentration and trouble come from logic on clk; keys are pins
// Notes:   APB slave answers with no wait states
// How it works
// - Menu opens only after confirm key held two seconds in display mode
// - Unlatched alarm clears on release; latched alarm waits for reset key
// - Energize off: contact open normally, closes on trouble or alarm
// - Energize on: contact closed normally, opens on trouble or alarm
// - First level limited to one to ninety percent of full scale
// - First alarm direction selects high or low acting
// - First high: set above level plus band, release below level minus band
// - First low: set below level minus band, release above level plus band
// - Dead bands reset to zero
// - First dwell zero to thirty seconds in one-second steps
// - Alarm triggers only after set condition holds for whole dwell
// - Contact enable off keeps alarm away from its relay contact
// - Second level limited to one to one hundred percent of full scale
// - Second alarm has its own direction
// - Menu steps in fixed order, each item committed by confirm key
// - Second alarm uses same dead band set and release scheme
// - Second dwell zero to thirty seconds in one-second steps
`default_nettype none
module gat_alarm #(
    parameter int SEC_CYCLES = gat_pkg::SEC_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire gat_pkg::gat_apb_req_t apb_req,
    output gat_pkg::gat_apb_rsp_t     apb_rsp,
    input  wire gat_pkg::gat_keys_t   keys,
    input  wire logic [15:0]          conc,
    input  wire logic                 trouble,
    output logic                      relay1_closed,
    output logic                      relay2_closed,
    output logic                      alarm1,
    output logic                      alarm2,
    output gat_pkg::gat_menu_t        menu_item,
    output logic [6:0]                edit_value,
    output logic                      irq
);
    import gat_pkg::*;

    gat_state_t s_q;
    gat_state_t s_d;

    function automatic logic [6:0] item_min(input gat_menu_t m);
        case (m)
            MENU_A1_LVL: item_min = A1_MIN_PCT;
            MENU_A2_LVL: item_min = A2_MIN_PCT;
            default:     item_min = 7'h00;
        endcase
    endfunction

    function automatic logic [6:0] item_max(input gat_menu_t m);
        case (m)
            MENU_A1_LVL:   item_max = A1_MAX_PCT;
            MENU_A2_LVL:   item_max = A2_MAX_PCT;
            MENU_A1_DB,
            MENU_A2_DB:    item_max = DB_MAX_PCT;
            MENU_A1_DWELL,
            MENU_A2_DWELL: item_max = DWELL_MAX_SEC;
            MENU_DISP,
            MENU_END:      item_max = 7'h00;
            default:       item_max = 7'h01;
        endcase
    endfunction

    // Direction items show 1 for high acting, 0 for low acting
    function automatic logic [6:0] cfg_get(input gat_cfg_t c, input gat_menu_t m);
        case (m)
            MENU_LATCH:    cfg_get = {6'h00, c.latch};
            MENU_ENERG:    cfg_get = {6'h00, c.energize};
            MENU_A1_LVL:   cfg_get = c.a1_lvl;
            MENU_A1_DIR:   cfg_get = {6'h00, ~c.a1_low};
            MENU_A1_DB:    cfg_get = c.a1_db;
            MENU_A1_DWELL: cfg_get = {2'h0, c.a1_dwell};
            MENU_A1_CONT:  cfg_get = {6'h00, c.a1_cont};
            MENU_A2_LVL:   cfg_get = c.a2_lvl;
            MENU_A2_DIR:   cfg_get = {6'h00, ~c.a2_low};
            MENU_A2_DB:    cfg_get = c.a2_db;
            MENU_A2_DWELL: cfg_get = {2'h0, c.a2_dwell};
            MENU_A2_CONT:  cfg_get = {6'h00, c.a2_cont};
            default:       cfg_get = 7'h00;
        endcase
    endfunction

    function automatic gat_cfg_t cfg_put(input gat_cfg_t c, input gat_menu_t m,
                                         input logic [6:0] v);
        gat_cfg_t r;
        r = c;
        case (m)
            MENU_LATCH:    r.latch    = v[0];
            MENU_ENERG:    r.energize = v[0];
            MENU_A1_LVL:   r.a1_lvl   = v;
            MENU_A1_DIR:   r.a1_low   = ~v[0];
            MENU_A1_DB:    r.a1_db    = v;
            MENU_A1_DWELL: r.a1_dwell = v[4:0];
            MENU_A1_CONT:  r.a1_cont  = v[0];
            MENU_A2_LVL:   r.a2_lvl   = v;
            MENU_A2_DIR:   r.a2_low   = ~v[0];
            MENU_A2_DB:    r.a2_db    = v;
            MENU_A2_DWELL: r.a2_dwell = v[4:0];
            MENU_A2_CONT:  r.a2_cont  = v[0];
            default:       r = c;
        endcase
        cfg_put = r;
    endfunction

    // Full scale times percent, both bounds of the hysteresis window
    function automatic logic signed [31:0] bound(input logic [15:0] fs,
                                                 input logic [6:0] lvl,
                                                 input logic [6:0] db,
                                                 input logic upper);
        logic signed [31:0] f;
        f = $signed({16'h0000, fs});
        if (upper)
            bound = f * $signed({25'h0, lvl}) + f * $signed({25'h0, db});
        else
            bound = f * $signed({25'h0, lvl}) - f * $signed({25'h0, db});
    endfunction

    logic signed [31:0] conc_x;
    logic signed [31:0] hi1;
    logic signed [31:0] lo1;
    logic signed [31:0] hi2;
    logic signed [31:0] lo2;
    logic               set1;
    logic               rel1;
    logic               set2;
    logic               rel2;
    logic               trig1;
    logic               trig2;
    logic               confirm_press;
    logic               up_press;
    logic               down_press;
    logic               reset_press;
    logic               commit;
    logic               setup;
    logic               wr;
    logic [EV_W-1:0]    ev;
    logic [EV_W-1:0]    w1c;

    always_comb
    begin
        conc_x = $signed({16'h0000, conc}) * $signed({25'h0, PCT_SCALE});
        hi1 = bound(s_q.fs, s_q.cfg.a1_lvl, s_q.cfg.a1_db, 1'b1);
        lo1 = bound(s_q.fs, s_q.cfg.a1_lvl, s_q.cfg.a1_db, 1'b0);
        hi2 = bound(s_q.fs, s_q.cfg.a2_lvl, s_q.cfg.a2_db, 1'b1);
        lo2 = bound(s_q.fs, s_q.cfg.a2_lvl, s_q.cfg.a2_db, 1'b0);
        set1 = s_q.cfg.a1_low ? (conc_x <= lo1) : (conc_x >= hi1);
        rel1 = s_q.cfg.a1_low ? (conc_x > hi1) : (conc_x < lo1);
        set2 = s_q.cfg.a2_low ? (conc_x <= lo2) : (conc_x >= hi2);
        rel2 = s_q.cfg.a2_low ? (conc_x > hi2) : (conc_x < lo2);
        // Zero dwell triggers at once; otherwise a full dwell must pass
        trig1 = set1 && (s_q.cfg.a1_dwell == 5'h00 || s_q.dwell1 > s_q.cfg.a1_dwell);
        trig2 = set2 && (s_q.cfg.a2_dwell == 5'h00 || s_q.dwell2 > s_q.cfg.a2_dwell);
        confirm_press = s_q.key_s.confirm_key && !s_q.key_d.confirm_key;
        up_press      = s_q.key_s.up_key && !s_q.key_d.up_key;
        down_press    = s_q.key_s.down_key && !s_q.key_d.down_key;
        reset_press   = s_q.key_s.reset_key && !s_q.key_d.reset_key;
        commit = confirm_press && s_q.menu != MENU_DISP && s_q.menu != MENU_END;
        setup = apb_req.psel && !apb_req.penable;
        wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;
    end

    always_comb
    begin
        s_d = s_q;
        // Key synchroniser and edge history
        s_d.key_m = keys;
        s_d.key_s = s_q.key_m;
        s_d.key_d = s_q.key_s;
        // One-second tick
        if (s_q.div == DIV_W'(SEC_CYCLES - 1))
        begin
            s_d.div  = '0;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.div  = s_q.div + 1'b1;
            s_d.tick = 1'b0;
        end
        // Long press detection in display mode
        s_d.hold = 2'h0;
        if (s_q.menu == MENU_DISP && s_q.key_s.confirm_key)
            s_d.hold = s_q.tick ? s_q.hold + 1'b1 : s_q.hold;
        case (s_q.menu)
            MENU_DISP:
            begin
                if (s_q.key_s.confirm_key && s_q.tick && s_q.hold == HOLD_TICKS - 2'h1)
                begin
                    s_d.menu = MENU_LATCH;
                    s_d.edit = cfg_get(s_q.cfg, MENU_LATCH);
                    s_d.hold = 2'h0;
                end
            end
            MENU_END:
            begin
                if (confirm_press)
                    s_d.menu = MENU_DISP;
            end
            default:
            begin
                if (commit)
                begin
                    s_d.cfg  = cfg_put(s_q.cfg, s_q.menu, s_q.edit);
                    s_d.menu = gat_menu_t'(4'(s_q.menu) + 4'h1);
                    s_d.edit = cfg_get(s_q.cfg, gat_menu_t'(4'(s_q.menu) + 4'h1));
                end
                else if (up_press && s_q.edit < item_max(s_q.menu))
                    s_d.edit = s_q.edit + 7'h01;
                else if (down_press && s_q.edit > item_min(s_q.menu))
                    s_d.edit = s_q.edit - 7'h01;
            end
        endcase
        // Dwell counters restart whenever the set condition drops
        s_d.dwell1 = !set1 ? 5'h00 : (s_q.tick && s_q.dwell1 != 5'h1f) ? s_q.dwell1 + 5'h01
                   : s_q.dwell1;
        s_d.dwell2 = !set2 ? 5'h00 : (s_q.tick && s_q.dwell2 != 5'h1f) ? s_q.dwell2 + 5'h01
                   : s_q.dwell2;
        // Alarm state with latch handling
        if (!s_q.alarm1)
            s_d.alarm1 = trig1;
        else if (s_q.cfg.latch ? reset_press : rel1)
            s_d.alarm1 = 1'b0;
        if (!s_q.alarm2)
            s_d.alarm2 = trig2;
        else if (s_q.cfg.latch ? reset_press : rel2)
            s_d.alarm2 = 1'b0;
        // Relay drive
        s_d.relay1 = s_q.cfg.energize ^ ((s_q.alarm1 && s_q.cfg.a1_cont) || trouble);
        s_d.relay2 = s_q.cfg.energize ^ ((s_q.alarm2 && s_q.cfg.a2_cont) || trouble);
        // Interrupt events, set wins over write-one clear
        ev = '0;
        ev[EV_A1_SET] = !s_q.alarm1 && trig1;
        ev[EV_A2_SET] = !s_q.alarm2 && trig2;
        ev[EV_A1_CLR] = s_q.alarm1 && !s_d.alarm1;
        ev[EV_A2_CLR] = s_q.alarm2 && !s_d.alarm2;
        ev[EV_COMMIT] = commit;
        w1c = '0;
        if (wr && apb_req.paddr == ADDR_INT_STATUS)
            w1c = apb_req.pwdata[EV_W-1:0];
        s_d.int_st = (s_q.int_st & ~w1c) | ev;
        if (wr && apb_req.paddr == ADDR_INT_MASK)
            s_d.int_mask = apb_req.pwdata[EV_W-1:0];
        if (wr && apb_req.paddr == ADDR_FULL_SCALE)
            s_d.fs = apb_req.pwdata[15:0];
        s_d.irq = |(s_d.int_st & s_d.int_mask);
        // Read data is prepared in the setup cycle
        if (setup)
        begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = '0;
            case (apb_req.paddr)
                ADDR_FULL_SCALE: s_d.prdata = {16'h0000, s_q.fs};
                ADDR_STATUS:     s_d.prdata = {22'h000000, s_q.menu, s_q.irq, trouble,
                                               s_q.relay2, s_q.relay1, s_q.alarm2, s_q.alarm1};
                ADDR_CFG:        s_d.prdata = {26'h0000000, s_q.cfg.a2_cont, s_q.cfg.a1_cont,
                                               s_q.cfg.a2_low, s_q.cfg.a1_low,
                                               s_q.cfg.energize, s_q.cfg.latch};
                ADDR_LEVELS:     s_d.prdata = {1'b0, s_q.cfg.a2_db, 1'b0, s_q.cfg.a2_lvl,
                                               1'b0, s_q.cfg.a1_db, 1'b0, s_q.cfg.a1_lvl};
                ADDR_DWELL:      s_d.prdata = {19'h00000, s_q.cfg.a2_dwell, 3'h0,
                                               s_q.cfg.a1_dwell};
                ADDR_INT_STATUS: s_d.prdata = {27'h0000000, s_q.int_st};
                ADDR_INT_MASK:   s_d.prdata = {27'h0000000, s_q.int_mask};
                default:         s_d.pslverr = 1'b1;
            endcase
            if (apb_req.pwrite)
                s_d.prdata = '0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q      <= '0;
            s_q.cfg  <= CFG_RESET;
            s_q.fs   <= FS_RESET;
            s_q.menu <= MENU_DISP;
        end
        else
            s_q <= s_d;
    end

    assign apb_rsp.prdata  = s_q.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = s_q.pslverr;
    assign relay1_closed   = s_q.relay1;
    assign relay2_closed   = s_q.relay2;
    assign alarm1          = s_q.alarm1;
    assign alarm2          = s_q.alarm2;
    assign menu_item       = s_q.menu;
    assign edit_value      = s_q.edit;
    assign irq             = s_q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_menu_hold_entry: assert property (
        (s_q.menu == MENU_DISP ##1 s_q.menu != MENU_DISP)
        |-> $past(s_q.key_s.confirm_key, 1) && $past(s_q.tick, 1))
        else $error("menu opened without long press");
    a_latch_holds: assert property (
        s_q.cfg.latch && s_q.alarm1 && !reset_press |=> s_q.alarm1)
        else $error("latched alarm dropped");
    a_unlatched_release: assert property (
        !s_q.cfg.latch && s_q.alarm1 && !s_q.cfg.a1_low && conc_x < lo1 |=> !s_q.alarm1)
        else $error("high alarm did not release");
    a_low_set_blocked: assert property (
        !s_q.alarm1 && s_q.cfg.a1_low && conc_x > lo1 |=> !s_q.alarm1)
        else $error("low alarm set outside window");
    a_relay_off_mode: assert property (
        !s_q.cfg.energize && trouble |=> s_q.relay1 && s_q.relay2)
        else $error("relay not closed on trouble");
    a_relay_on_mode: assert property (
        s_q.cfg.energize && s_q.alarm1 && s_q.cfg.a1_cont |=> !s_q.relay1)
        else $error("energized relay not opened on alarm");
    a_contact_disable: assert property (
        !s_q.cfg.a2_cont && !trouble |=> s_q.relay2 == $past(s_q.cfg.energize))
        else $error("disabled contact driven");
    a_dwell_restart: assert property (
        s_q.dwell1 != 5'h00 && !set1 |=> s_q.dwell1 == 5'h00)
        else $error("dwell count kept after drop");
    a_alarm_after_dwell: assert property (
        $rose(s_q.alarm2) |-> $past(trig2))
        else $error("alarm without full dwell");
    a_cfg_commit_only: assert property (
        s_q.menu == MENU_DISP |=> $stable(s_q.cfg))
        else $error("config changed outside menu");
    a_level_range: assert property (
        s_q.cfg.a1_lvl >= A1_MIN_PCT && s_q.cfg.a1_lvl <= A1_MAX_PCT
        && s_q.cfg.a2_lvl <= A2_MAX_PCT && s_q.cfg.a1_dwell <= 5'h1e)
        else $error("setting out of range");
    a_menu_order: assert property (
        commit && s_q.menu == MENU_A1_CONT |=> s_q.menu == MENU_A2_LVL)
        else $error("menu order broken");
    a_latch_holds2: assert property (
        s_q.cfg.latch && s_q.alarm2 && !reset_press |=> s_q.alarm2)
        else $error("latched second alarm dropped");
    a_low2_set_blocked: assert property (
        !s_q.alarm2 && s_q.cfg.a2_low && conc_x > lo2 |=> !s_q.alarm2)
        else $error("second low alarm set outside window");
    a_low2_release: assert property (
        !s_q.cfg.latch && s_q.alarm2 && s_q.cfg.a2_low && conc_x > hi2 |=> !s_q.alarm2)
        else $error("second low alarm did not release");
    a_dwell_length: assert property (
        $rose(s_q.alarm1) && $past(s_q.cfg.a1_dwell) != 5'h00
        |-> $past(s_q.dwell1) > $past(s_q.cfg.a1_dwell))
        else $error("first alarm before dwell ended");
    a_dwell_length2: assert property (
        $rose(s_q.alarm2) && $past(s_q.cfg.a2_dwell) != 5'h00
        |-> $past(s_q.dwell2) > $past(s_q.cfg.a2_dwell))
        else $error("second alarm before dwell ended");
    a_tick_single: assert property (
        s_q.tick |=> !s_q.tick)
        else $error("tick longer than one cycle");
    a_edit_limits: assert property (
        s_q.edit <= item_max(s_q.menu) && s_q.edit >= item_min(s_q.menu))
        else $error("edit value out of range");
    a_commit_apply: assert property (
        commit && s_q.menu == MENU_A1_LVL |=> s_q.cfg.a1_lvl == $past(s_q.edit))
        else $error("committed level not applied");

    c_alarm1_set: cover property (!s_q.alarm1 ##1 s_q.alarm1);
    c_latched_reset: cover property (s_q.cfg.latch && s_q.alarm1 ##1 !s_q.alarm1);
    c_menu_round: cover property (s_q.menu == MENU_END ##1 s_q.menu == MENU_DISP);
    c_alarm2_low: cover property (s_q.cfg.a2_low && !s_q.alarm2 ##1 s_q.alarm2);
    c_dwell_alarm: cover property (s_q.cfg.a1_dwell != 5'h00 && !s_q.alarm1 ##1 s_q.alarm1);
endmodule
`default_nettype wire

//--- shared/gat_pkg.sv
// Purpose: Shared constants and types of the gas alarm threshold logic
// Assumes: 250 MHz clock, APB register access
// Notes:   Levels and dead bands are percent of the full-scale register
`default_nettype none
package gat_pkg;
    localparam int CLK_HZ        = 250_000_000;
    localparam int TICK_SEC      = 1;
    localparam int SEC_CYCLES    = CLK_HZ * TICK_SEC;
    localparam int DIV_W         = 28;
    localparam int HOLD_SEC      = 2;
    localparam logic [1:0] HOLD_TICKS = 2'(HOLD_SEC + 1);
    localparam logic [6:0] A1_MIN_PCT = 7'h01;
    localparam logic [6:0] A1_MAX_PCT = 7'h5a;
    localparam logic [6:0] A2_MIN_PCT = 7'h01;
    localparam logic [6:0] A2_MAX_PCT = 7'h64;
    localparam logic [6:0] DB_MAX_PCT = 7'h14;
    localparam logic [6:0] DWELL_MAX_SEC = 7'h1e;
    localparam logic [6:0] PCT_SCALE  = 7'h64;
    localparam logic [15:0] FS_RESET  = 16'h0064;
    localparam logic [7:0] ADDR_FULL_SCALE = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_CFG        = 8'h08;
    localparam logic [7:0] ADDR_LEVELS     = 8'h0c;
    localparam logic [7:0] ADDR_DWELL      = 8'h10;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK   = 8'h18;
    localparam int EV_W       = 5;
    localparam int EV_A1_SET  = 0;
    localparam int EV_A2_SET  = 1;
    localparam int EV_A1_CLR  = 2;
    localparam int EV_A2_CLR  = 3;
    localparam int EV_COMMIT  = 4;

    typedef enum logic [3:0] {
        MENU_DISP, MENU_LATCH, MENU_ENERG,
        MENU_A1_LVL, MENU_A1_DIR, MENU_A1_DB, MENU_A1_DWELL, MENU_A1_CONT,
        MENU_A2_LVL, MENU_A2_DIR, MENU_A2_DB, MENU_A2_DWELL, MENU_A2_CONT,
        MENU_END
    } gat_menu_t;

    typedef struct packed {
        logic       latch;
        logic       energize;
        logic       a1_low;
        logic       a2_low;
        logic       a1_cont;
        logic       a2_cont;
        logic [6:0] a1_lvl;
        logic [6:0] a2_lvl;
        logic [6:0] a1_db;
        logic [6:0] a2_db;
        logic [4:0] a1_dwell;
        logic [4:0] a2_dwell;
    } gat_cfg_t;

    localparam gat_cfg_t CFG_RESET = '{latch: 1'b0, energize: 1'b0, a1_low: 1'b0,
        a2_low: 1'b0, a1_cont: 1'b1, a2_cont: 1'b1, a1_lvl: 7'h14, a2_lvl: 7'h28,
        a1_db: 7'h00, a2_db: 7'h00, a1_dwell: 5'h00, a2_dwell: 5'h00};

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } gat_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gat_apb_rsp_t;

    typedef struct packed {
        logic confirm_key;
        logic up_key;
        logic down_key;
        logic reset_key;
    } gat_keys_t;

    typedef struct packed {
        gat_cfg_t          cfg;
        gat_menu_t         menu;
        logic [6:0]        edit;
        gat_keys_t         key_m;
        gat_keys_t         key_s;
        gat_keys_t         key_d;
        logic [DIV_W-1:0]  div;
        logic              tick;
        logic [1:0]        hold;
        logic [4:0]        dwell1;
        logic [4:0]        dwell2;
        logic              alarm1;
        logic              alarm2;
        logic              relay1;
        logic              relay2;
        logic [15:0]       fs;
        logic [EV_W-1:0]   int_st;
        logic [EV_W-1:0]   int_mask;
        logic              irq;
        logic [31:0]       prdata;
        logic              pslverr;
    } gat_state_t;
endpackage
`default_nettype wire

//--- testbench/gat_keypad_model.sv
// Purpose: Keypad in front of the alarm menu, pressing keys as a user does
// Assumes: Key pins are active high levels sampled on clk
// Notes:   Press length is given in clock cycles by the caller
`default_nettype none
module gat_keypad_model (
    input  wire logic        clk,
    output gat_pkg::gat_keys_t keys
);
    timeunit 1ns;
    timeprecision 1ps;
    import gat_pkg::*;

    initial keys = '0;

    // Holds one key for a number of cycles, then leaves a quiet gap
    task automatic press(input int idx, input int cycles);
        @(posedge clk);
        keys[idx] <= 1'b1;
        repeat (cycles) @(posedge clk);
        keys[idx] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- testbench/gat_alarm_tb_top.sv
// Purpose: Self-checking bench of the gas alarm threshold logic
// Assumes: One-second tick shortened to ten cycles
// Notes:   Read results are checked by a monitor fed from a queue
`default_nettype none
`define CHK(nm, e, a) \
    begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module gat_alarm_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gat_pkg::*;
    typedef struct packed {logic chk; logic err; logic [31:0] data;} gat_exp_t;
    localparam int K_CONF = 3;
    localparam int K_UP   = 2;
    localparam int K_DN   = 1;
    localparam int K_RST  = 0;
    logic         clk;
    logic         rst;
    gat_apb_req_t req;
    gat_apb_rsp_t rsp;
    gat_keys_t    keys;
    logic [15:0]  conc;
    logic         trouble;
    logic         relay1_closed;
    logic         relay2_closed;
    logic         alarm1;
    logic         alarm2;
    gat_menu_t    menu_item;
    logic [6:0]   edit_value;
    logic         irq;
    gat_exp_t     exp_q[$];
    gat_exp_t     ent;
    int           failures;
    int           comparisons;
    int           ups[12] = '{1, 1, 1, 0, 2, 2, 0, 0, -1, 0, 0, 0};

    gat_alarm #(.SEC_CYCLES(10)) i_dut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .keys(keys), .conc(conc), .trouble(trouble), .relay1_closed(relay1_closed),
        .relay2_closed(relay2_closed), .alarm1(alarm1), .alarm2(alarm2),
        .menu_item(menu_item), .edit_value(edit_value), .irq(irq));
    gat_keypad_model i_keys (.clk(clk), .keys(keys));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic chk, input logic [31:0] ex, input logic er);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        if (!wr) exp_q.push_back('{chk, er, ex});
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1)
            @(posedge clk);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0, 1'b1, ex, 1'b0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
    endtask

    always @(posedge clk)
        if (req.psel && req.penable && rsp.pready && !req.pwrite && exp_q.size() > 0)
        begin
            ent = exp_q.pop_front();
            if (ent.chk) `CHK("prdata", ent.data, rsp.prdata)
            `CHK("pslverr", ent.err, rsp.pslverr)
        end

    initial
    begin
        #100000;
        failures++;
        final_report();
    end

    initial
    begin
        int n;
        logic [31:0] r;
        req = '0;
        conc = 16'h0000;
        trouble = 1'b0;
        rst = 1'b1;
        void'($urandom(32'hb656));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_FULL_SCALE, 32'h00000064);
        rd(ADDR_CFG, 32'h00000030);
        rd(ADDR_LEVELS, 32'h00280014);
        rd(ADDR_DWELL, 32'h00000000);
        apb(1'b0, 8'h1c, 32'h0, 1'b0, 32'h0, 1'b1);
        r = $urandom() & 32'h1f;
        wr(ADDR_INT_MASK, r);
        rd(ADDR_INT_MASK, r);
        wr(ADDR_INT_MASK, 32'h00000001);
        $display("test registers done");
        repeat (6)
        begin
            @(posedge clk);
            conc <= 16'($urandom_range(19, 0));
            repeat (3) @(posedge clk);
            `CHK("alarm1", 1'b0, alarm1)
        end
        @(posedge clk);
        conc <= 16'd25;
        repeat (4) @(posedge clk);
        `CHK("alarm1", 1'b1, alarm1)
        `CHK("relay1", 1'b1, relay1_closed)
        `CHK("irq", 1'b1, irq)
        `CHK("alarm2", 1'b0, alarm2)
        wr(ADDR_INT_STATUS, 32'h0000001f);
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        conc <= 16'd45;
        repeat (4) @(posedge clk);
        `CHK("relay2", 1'b1, relay2_closed)
        conc <= 16'd10;
        repeat (4) @(posedge clk);
        `CHK("alarm1", 1'b0, alarm1)
        `CHK("alarm2", 1'b0, alarm2)
        trouble <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("relay_trouble", 2'b11, {relay1_closed, relay2_closed})
        trouble <= 1'b0;
        $display("test unlatched done");
        i_keys.press(K_CONF, 12);
        `CHK("menu_short", MENU_DISP, menu_item)
        i_keys.press(K_CONF, 40);
        for (int i = 0; i < 12; i++)
        begin
            `CHK("menu_item", gat_menu_t'(i + 1), menu_item)
            repeat (ups[i] < 0 ? -ups[i] : ups[i])
                i_keys.press(ups[i] < 0 ? K_DN : K_UP, 2);
            if (i == 2)
            begin
                `CHK("edit", 7'h15, edit_value)
                rd(ADDR_LEVELS, 32'h00280014);
            end
            i_keys.press(K_CONF, 2);
        end
        `CHK("menu_end", MENU_END, menu_item)
        i_keys.press(K_CONF, 2);
        `CHK("menu_disp", MENU_DISP, menu_item)
        rd(ADDR_CFG, 32'h0000003b);
        rd(ADDR_LEVELS, 32'h00280215);
        rd(ADDR_STATUS, 32'h00000006);
        rd(ADDR_DWELL, 32'h00000002);
        $display("test menu done");
        `CHK("relay1_norm", 1'b1, relay1_closed)
        conc <= 16'd25;
        repeat (12) @(posedge clk);
        conc <= 16'd10;
        repeat (30) @(posedge clk);
        `CHK("alarm1_short", 1'b0, alarm1)
        conc <= 16'd25;
        n = 0;
        while (alarm1 !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            n++;
        end
        `CHK("dwell_span", 1'b1, (n >= 20 && n <= 34))
        repeat (2) @(posedge clk);
        `CHK("relay1_alarm", 1'b0, relay1_closed)
        conc <= 16'd10;
        repeat (10) @(posedge clk);
        `CHK("alarm1_latched", 1'b1, alarm1)
        i_keys.press(K_RST, 2);
        `CHK("alarm1_reset", 1'b0, alarm1)
        conc <= 16'd22;
        repeat (40) @(posedge clk);
        `CHK("alarm1_band", 1'b0, alarm1)
        $display("test latched done");
        final_report();
    end
endmodule
`default_nettype wire
